// ### rtl/mate_pkg.sv
/*
  mate_pkg: constants, types and operation codes of the address table engine.
  assumes: a single 20 MHz core clock shared by all users of these types.
*/
`default_nettype none
package mate_pkg;
  localparam int NPORT    = 8;                  // switch ports
  localparam int NENT     = 16;                 // address table entries
  localparam int NFLT     = 8;                  // filter list entries
  localparam int IDXW     = 4;                  // table index width
  localparam int FIDXW    = 3;                  // filter index width
  localparam int PIDXW    = 3;                  // port number width

  localparam int CLK_PERIOD_NS = 50;            // core clock period
  localparam int SEC_NS        = 1_000_000_000; // one second
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  typedef logic [47:0]      mate_mac_t;
  typedef logic [12:0]      mate_vid_t;         // 13 bits so 4096 fits
  typedef logic [NPORT-1:0] mate_pmap_t;
  typedef logic [9:0]       mate_age_t;         // seconds
  typedef logic [60:0]      mate_key_t;         // {vid, mac}

  localparam mate_age_t AGE_MIN = 10'h00a;      // 10 s
  localparam mate_age_t AGE_MAX = 10'h276;      // 630 s
  localparam mate_age_t AGE_DEF = 10'h12c;      // 300 s
  localparam mate_vid_t VID_MIN = 13'h0001;
  localparam mate_vid_t VID_MAX = 13'h1000;     // 4096

  // management operations, one-hot
  typedef enum logic [6:0] {
    MATE_OP_ADD_ST   = 7'h01,
    MATE_OP_DEL_ST   = 7'h02,
    MATE_OP_ADD_FL   = 7'h04,
    MATE_OP_DEL_FL   = 7'h08,
    MATE_OP_SET_AGE  = 7'h10,
    MATE_OP_FLUSH    = 7'h20,
    MATE_OP_RD_NEXT  = 7'h40
  } mate_op_e;

  typedef struct packed {
    logic       vld;
    logic       stat;
    mate_vid_t  vid;
    mate_mac_t  mac;
    mate_pmap_t ports;
    mate_age_t  age;
  } mate_ent_s;

  typedef struct packed {
    logic      vld;
    mate_vid_t vid;
    mate_mac_t mac;
  } mate_flt_s;

  typedef struct packed {
    mate_vid_t         vid;
    mate_mac_t         dmac;
    mate_mac_t         smac;
    logic [PIDXW-1:0]  port;    // ingress port number
    mate_pmap_t        vmemb;   // member ports of vid
  } mate_frm_s;

  typedef struct packed {
    mate_pmap_t fwd;            // egress ports
    logic       drop;
    logic       flood;
  } mate_res_s;

  typedef struct packed {
    mate_op_e   op;
    mate_mac_t  mac;
    mate_vid_t  vid;
    mate_pmap_t ports;
    mate_age_t  age;
  } mate_mreq_s;

  typedef struct packed {
    logic       done;
    logic       err;
    logic       found;
    logic       stat;
    mate_vid_t  vid;
    mate_mac_t  mac;
    mate_pmap_t ports;
  } mate_mrsp_s;
endpackage
`default_nettype wire

// ### rtl/mate_tick.sv
/*
  mate_tick: one-second tick generator for the aging logic.
  assumes: CLK is the core clock; CYCLES is the clock count per second.
*/
`timescale 1ns/10ps
`default_nettype none
module mate_tick #(
  parameter int unsigned CYCLES = mate_pkg::SEC_CYCLES
) (
  input  wire logic CLK,
  input  wire logic RST,
  output var  logic TICK
);
  logic [24:0] cnt_ff;   // cycles into the current second
  logic        tick_ff;  // registered pulse
  wire         wrap = (cnt_ff == 25'(CYCLES - 1));

  // free running prescaler; pulse lasts one cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_ff  <= 25'h0000000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? 25'h0000000 : cnt_ff + 25'h0000001;
      tick_ff <= wrap;
    end
  end

  assign TICK = tick_ff;
endmodule
`default_nettype wire

// ### rtl/mate_top.sv
/*
  mate_top: forwarding address table engine of a small ethernet switch.
  lookup and learning per frame, static entries, filter list, aging, ordered readout.
  assumes: frame requests and management requests come from logic on CLK.
*/
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - forward by destination mac lookup
// - table holds static and learned entries
// - static entries only via management, kept until deleted
// - source mac and port learn or refresh
// - idle dynamic entries removed after aging time
// - aging 10..630 s, default 300, readable
// - readout ordered by vlan then mac
// - drop frames matching filter mac and vlan
module mate_top #(
  parameter int unsigned SEC_CYCLES = mate_pkg::SEC_CYCLES
) (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                FRM_VALID,
  input  wire mate_pkg::mate_frm_s FRM,
  output var  logic                RES_VALID,
  output var  mate_pkg::mate_res_s RES,
  input  wire logic                MGT_VALID,
  input  wire mate_pkg::mate_mreq_s MGT,
  output var  mate_pkg::mate_mrsp_s MGT_RSP,
  output var  mate_pkg::mate_age_t AGE_NOW
);
  mate_pkg::mate_ent_s  tbl_ff [mate_pkg::NENT]; // address table
  mate_pkg::mate_flt_s  flt_ff [mate_pkg::NFLT]; // filter list
  mate_pkg::mate_age_t  age_ff;                  // aging period, seconds
  mate_pkg::mate_res_s  res_ff;
  logic                 res_vld_ff;
  mate_pkg::mate_mrsp_s rsp_ff;
  logic                 tick;                    // one-second pulse

  mate_tick #(.CYCLES(SEC_CYCLES)) u_tick (
    .CLK  (CLK),
    .RST  (RST),
    .TICK (tick)
  );

  // per-entry match flags
  logic [mate_pkg::NENT-1:0] d_hit;   // destination match in vid
  logic [mate_pkg::NENT-1:0] s_hit;   // source match in vid
  logic [mate_pkg::NENT-1:0] m_hit;   // management key match
  logic [mate_pkg::NENT-1:0] free_v;  // empty slots
  logic [mate_pkg::NENT-1:0] lrn_we;  // learn write per entry
  logic [mate_pkg::NENT-1:0] rd_cand; // entries above the readout key
  logic [mate_pkg::NFLT-1:0] f_hit;   // frame hits filter
  logic [mate_pkg::NFLT-1:0] fm_hit;  // management hits filter
  logic [mate_pkg::NFLT-1:0] f_free;
  mate_pkg::mate_key_t       ent_key [mate_pkg::NENT];
  mate_pkg::mate_pmap_t      hit_ports [mate_pkg::NENT+1];

  wire mate_pkg::mate_key_t rd_key = {MGT.vid, MGT.mac};
  wire op_add_st = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_ADD_ST);
  wire op_del_st = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_DEL_ST);
  wire op_add_fl = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_ADD_FL);
  wire op_del_fl = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_DEL_FL);
  wire op_age    = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_SET_AGE);
  wire op_flush  = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_FLUSH);
  wire op_rd     = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_RD_NEXT);
  wire age_ok    = (MGT.age >= mate_pkg::AGE_MIN) && (MGT.age <= mate_pkg::AGE_MAX);
  wire vid_ok    = (MGT.vid >= mate_pkg::VID_MIN) && (MGT.vid <= mate_pkg::VID_MAX);

  assign hit_ports[0] = '0;

  // compare logic, one copy per table entry
  for (genvar i = 0; i < mate_pkg::NENT; i++) begin : g_cmp
    assign ent_key[i] = {tbl_ff[i].vid, tbl_ff[i].mac};
    assign d_hit[i]   = tbl_ff[i].vld && (tbl_ff[i].vid == FRM.vid)
                        && (tbl_ff[i].mac == FRM.dmac);
    assign s_hit[i]   = tbl_ff[i].vld && (tbl_ff[i].vid == FRM.vid)
                        && (tbl_ff[i].mac == FRM.smac);
    assign m_hit[i]   = tbl_ff[i].vld && (ent_key[i] == rd_key);
    assign free_v[i]  = !tbl_ff[i].vld;
    assign rd_cand[i] = tbl_ff[i].vld && (ent_key[i] > rd_key);
    assign hit_ports[i+1] = hit_ports[i] | (d_hit[i] ? tbl_ff[i].ports : '0);
  end

  // compare logic, one copy per filter entry
  for (genvar k = 0; k < mate_pkg::NFLT; k++) begin : g_fcmp
    assign f_hit[k]  = flt_ff[k].vld && (flt_ff[k].vid == FRM.vid)
                       && ((flt_ff[k].mac == FRM.smac) || (flt_ff[k].mac == FRM.dmac));
    assign fm_hit[k] = flt_ff[k].vld && (flt_ff[k].vid == MGT.vid)
                       && (flt_ff[k].mac == MGT.mac);
    assign f_free[k] = !flt_ff[k].vld;
  end

  // lowest free slot of table and filter list
  logic [mate_pkg::IDXW-1:0]  free_idx;
  logic [mate_pkg::FIDXW-1:0] ffree_idx;
  always_comb begin
    free_idx  = '0;
    ffree_idx = '0;
    for (int i = mate_pkg::NENT - 1; i >= 0; i--) begin
      if (free_v[i]) begin
        free_idx = mate_pkg::IDXW'(i);
      end
    end
    for (int k = mate_pkg::NFLT - 1; k >= 0; k--) begin
      if (f_free[k]) begin
        ffree_idx = mate_pkg::FIDXW'(k);
      end
    end
  end

  // smallest key above the requested one; a full scan, but readout is rare
  logic [mate_pkg::IDXW-1:0] rd_idx;
  always_comb begin
    mate_pkg::mate_key_t best;
    best   = '1;
    rd_idx = '0;
    for (int i = 0; i < mate_pkg::NENT; i++) begin
      if (rd_cand[i] && (ent_key[i] <= best)) begin
        best   = ent_key[i];
        rd_idx = mate_pkg::IDXW'(i);
      end
    end
  end

  // frame side and management add decisions
  wire                       frm_drop  = |f_hit;
  wire                       d_any     = |d_hit;
  wire                       s_any     = |s_hit;
  wire mate_pkg::mate_pmap_t in_map    = mate_pkg::mate_pmap_t'(1) << FRM.port;
  wire                       lrn_go    = FRM_VALID && !frm_drop;
  wire                       st_alloc  = op_add_st && vid_ok && !(|m_hit) && (|free_v);
  wire                       st_err    = op_add_st && (!vid_ok || (!(|m_hit) && !(|free_v)));
  wire                       fl_alloc  = op_add_fl && vid_ok && !(|fm_hit) && (|f_free);
  wire                       fl_err    = op_add_fl && (!vid_ok || (!(|fm_hit) && !(|f_free)));

  // per-entry next state: aging, then learning, then management wins
  for (genvar i = 0; i < mate_pkg::NENT; i++) begin : g_ent
    mate_pkg::mate_ent_s nxt_ent;
    wire mate_pkg::mate_age_t age_inc = tbl_ff[i].age + 10'h001;
    // a static entry with the same source key is never overwritten by learning
    assign lrn_we[i] = lrn_go && ((s_hit[i] && !tbl_ff[i].stat)
                       || (!s_any && (|free_v) && (free_idx == mate_pkg::IDXW'(i))));
    always_comb begin
      nxt_ent = tbl_ff[i];
      if (tick && tbl_ff[i].vld && !tbl_ff[i].stat) begin
        nxt_ent.age = age_inc;
        if (age_inc >= age_ff) begin
          nxt_ent.vld = 1'b0;
        end
      end
      if (lrn_we[i]) begin
        nxt_ent.vld   = 1'b1;
        nxt_ent.stat  = 1'b0;
        nxt_ent.vid   = FRM.vid;
        nxt_ent.mac   = FRM.smac;
        nxt_ent.ports = in_map;
        nxt_ent.age   = '0;
      end
      if (op_flush && !tbl_ff[i].stat) begin
        nxt_ent.vld = 1'b0;
      end
      if ((op_add_st && vid_ok && m_hit[i])
          || (st_alloc && (free_idx == mate_pkg::IDXW'(i)))) begin
        nxt_ent.vld   = 1'b1;
        nxt_ent.stat  = 1'b1;
        nxt_ent.vid   = MGT.vid;
        nxt_ent.mac   = MGT.mac;
        nxt_ent.ports = MGT.ports;
        nxt_ent.age   = '0;
      end
      if (op_del_st && m_hit[i] && tbl_ff[i].stat) begin
        nxt_ent.vld = 1'b0;
      end
    end
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        tbl_ff[i] <= '0;
      end else begin
        tbl_ff[i] <= nxt_ent;
      end
    end
  end

  // filter list entries, written only by management
  for (genvar k = 0; k < mate_pkg::NFLT; k++) begin : g_flt
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        flt_ff[k] <= '0;
      end else if (fl_alloc && (ffree_idx == mate_pkg::FIDXW'(k))) begin
        flt_ff[k] <= '{vld: 1'b1, vid: MGT.vid, mac: MGT.mac};
      end else if (op_del_fl && fm_hit[k]) begin
        flt_ff[k] <= '0;
      end
    end
  end

  // aging period; out-of-range values are refused with err
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      age_ff <= mate_pkg::AGE_DEF;
    end else if (op_age && age_ok) begin
      age_ff <= MGT.age;
    end
  end

  // frame result, one cycle after the request
  mate_pkg::mate_res_s nxt_res;
  always_comb begin
    nxt_res = '0;
    if (frm_drop) begin
      nxt_res.drop = 1'b1;
    end else if (d_any) begin
      nxt_res.fwd = hit_ports[mate_pkg::NENT] & ~in_map;
    end else begin
      nxt_res.fwd   = FRM.vmemb & ~in_map;
      nxt_res.flood = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      res_vld_ff <= 1'b0;
      res_ff     <= '0;
    end else begin
      res_vld_ff <= FRM_VALID;
      res_ff     <= FRM_VALID ? nxt_res : '0;
    end
  end

  // management answer
  mate_pkg::mate_mrsp_s nxt_rsp;
  always_comb begin
    nxt_rsp      = '0;
    nxt_rsp.done = MGT_VALID;
    nxt_rsp.err  = st_err || fl_err || (op_age && !age_ok);
    unique case (1'b1)
      op_rd: begin
        nxt_rsp.found = |rd_cand;
        // found and the entry fields stay zero when the walk has run past the last entry; done is still set
        nxt_rsp.stat  = (|rd_cand) ? tbl_ff[rd_idx].stat : 1'b0;
        nxt_rsp.vid   = (|rd_cand) ? tbl_ff[rd_idx].vid : '0;
        nxt_rsp.mac   = (|rd_cand) ? tbl_ff[rd_idx].mac : '0;
        nxt_rsp.ports = (|rd_cand) ? tbl_ff[rd_idx].ports : '0;
      end
      op_del_st: begin
        nxt_rsp.found = |(m_hit);
      end
      op_del_fl: begin
        nxt_rsp.found = |fm_hit;
      end
      default: begin
        nxt_rsp.found = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff <= nxt_rsp;
    end
  end

  assign RES_VALID = res_vld_ff;
  assign RES       = res_ff;
  assign MGT_RSP   = rsp_ff;
  assign AGE_NOW   = age_ff;
endmodule
`default_nettype wire

// ### test/mate_asserts.sv
/*
  mate_asserts: port timing and value checks for mate_top.
  assumes: bound to mate_top; one clock, RST asynchronous active high.
*/
`timescale 1ns/10ps
`default_nettype none
module mate_asserts (
  input wire logic                 CLK,
  input wire logic                 RST,
  input wire logic                 FRM_VALID,
  input wire mate_pkg::mate_frm_s  FRM,
  input wire logic                 RES_VALID,
  input wire mate_pkg::mate_res_s  RES,
  input wire logic                 MGT_VALID,
  input wire mate_pkg::mate_mreq_s MGT,
  input wire mate_pkg::mate_mrsp_s MGT_RSP,
  input wire mate_pkg::mate_age_t  AGE_NOW
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // aging request decode, range taken from the package
  wire logic age_op = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_SET_AGE);
  wire logic age_ok = (MGT.age >= mate_pkg::AGE_MIN) && (MGT.age <= mate_pkg::AGE_MAX);
  // static add with a vlan outside the legal span
  wire logic vid_bad = MGT_VALID && (MGT.op == mate_pkg::MATE_OP_ADD_ST)
                       && ((MGT.vid < mate_pkg::VID_MIN) || (MGT.vid > mate_pkg::VID_MAX));
  // frame taken, answer one cycle later
  sequence s_ans; FRM_VALID ##1 RES_VALID; endsequence
  property p_res_lat; FRM_VALID |=> RES_VALID; endproperty
  property p_res_quiet; !FRM_VALID |=> !RES_VALID && (RES == 10'h000); endproperty
  property p_no_ingress; s_ans |-> !RES.fwd[$past(FRM.port)]; endproperty
  property p_flood;
    s_ans ##0 RES.flood |-> RES.fwd == ($past(FRM.vmemb) & ~(8'h01 << $past(FRM.port)));
  endproperty
  property p_drop; RES_VALID && RES.drop |-> RES.fwd == 8'h00; endproperty
  property p_done; MGT_VALID |=> MGT_RSP.done; endproperty
  property p_age_bad; age_op && !age_ok |=> MGT_RSP.err && $stable(AGE_NOW); endproperty
  property p_age_set; age_op && age_ok |=> AGE_NOW == $past(MGT.age); endproperty
  property p_age_rng; AGE_NOW >= mate_pkg::AGE_MIN && AGE_NOW <= mate_pkg::AGE_MAX; endproperty
  property p_vid_bad; vid_bad |=> MGT_RSP.err; endproperty
  a_res_lat: assert property (p_res_lat) else $error("no answer after frame");
  a_res_quiet: assert property (p_res_quiet) else $error("answer without frame");
  a_no_ingress: assert property (p_no_ingress) else $error("sent back to ingress");
  a_flood: assert property (p_flood) else $error("flood map wrong");
  a_drop: assert property (p_drop) else $error("dropped frame forwarded");
  a_done: assert property (p_done) else $error("management not done");
  a_age_bad: assert property (p_age_bad) else $error("bad aging accepted");
  a_age_set: assert property (p_age_set) else $error("aging not applied");
  a_age_rng: assert property (p_age_rng) else $error("aging out of span");
  a_vid_bad: assert property (p_vid_bad) else $error("bad vlan accepted");
endmodule
bind mate_top mate_asserts u_chk (
  .CLK(CLK), .RST(RST), .FRM_VALID(FRM_VALID), .FRM(FRM), .RES_VALID(RES_VALID),
  .RES(RES), .MGT_VALID(MGT_VALID), .MGT(MGT), .MGT_RSP(MGT_RSP), .AGE_NOW(AGE_NOW)
);
`default_nettype wire

// ### test/mate_partner.sv
/*
  mate_partner: ingress side model, sends frames and takes the answer.
  assumes: CLK is the core clock; bench calls send from one process only.
*/
`timescale 1ns/10ps
`default_nettype none
module mate_partner (
  input  wire logic                CLK,
  output var  logic                FRM_VALID,
  output var  mate_pkg::mate_frm_s FRM,
  input  wire logic                RES_VALID,
  input  wire mate_pkg::mate_res_s RES
);
  // idle at time zero
  initial begin
    FRM_VALID = 1'b0;
    FRM = '0;
  end
  // one frame: strobe for one cycle, answer read just after the taking edge
  task automatic send(input mate_pkg::mate_frm_s f, output logic v,
                      output mate_pkg::mate_res_s r);
    @(posedge CLK);
    #2;
    FRM_VALID = 1'b1;
    FRM = f;
    @(posedge CLK);
    #2;
    v = RES_VALID;
    r = RES;
    FRM_VALID = 1'b0;
    FRM = ~f; // released bus never shows the stale frame
  endtask
endmodule
`default_nettype wire

// ### test/mac_address_table_engine_bench.sv
/*
  mac_address_table_engine_bench: scenario tests of mate_top.
  assumes: mate_partner drives frames; second shortened to SEC cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module mac_address_table_engine_bench;
  localparam int unsigned SEC = 20;       // short second keeps aging runs small
  localparam logic [47:0] A = 48'h0a00_0000_00a0;
  localparam logic [47:0] B = 48'h0b00_0000_00b0;
  localparam logic [47:0] C = 48'h0000_0000_00c0; // lowest mac, static
  localparam logic [47:0] D = 48'h0d00_0000_00d0; // filtered
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 frm_valid, res_valid, v;
  logic                 mgt_valid = 1'b0;  // management strobe, idle low
  mate_pkg::mate_frm_s  frm;
  mate_pkg::mate_res_s  res, r;
  mate_pkg::mate_mreq_s mgt = '0;
  mate_pkg::mate_mrsp_s rsp_o, m;
  mate_pkg::mate_age_t  age_now;
  int                   n_fail = 0;
  int                   num_checks = 0;
  logic [9:0]           ages [4] = '{10'h009, 10'h00a, 10'h277, 10'h276};
  logic [9:0]           after [4] = '{10'h12c, 10'h00a, 10'h00a, 10'h276};
  // free running core clock
  always #25 clk = ~clk;
  mate_top #(.SEC_CYCLES(SEC)) dut (
    .CLK(clk), .RST(rst), .FRM_VALID(frm_valid), .FRM(frm), .RES_VALID(res_valid),
    .RES(res), .MGT_VALID(mgt_valid), .MGT(mgt), .MGT_RSP(rsp_o), .AGE_NOW(age_now)
  );
  mate_partner u_src (
    .CLK(clk), .FRM_VALID(frm_valid), .FRM(frm), .RES_VALID(res_valid), .RES(res)
  );
  // one comparison, four-state exact; wide enough for a whole management answer
  task automatic chk(input string what, input logic [79:0] e, input logic [79:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // one management request, response read after the taking edge
  task automatic mg(input mate_pkg::mate_op_e op, input logic [47:0] mac,
                    input logic [12:0] vid, input logic [7:0] pm, input logic [9:0] ag);
    @(posedge clk);
    #2;
    mgt_valid = 1'b1;
    mgt = '{op, mac, vid, pm, ag};
    @(posedge clk);
    #2;
    m = rsp_o;
    mgt_valid = 1'b0;
    mgt = ~mgt; // no stale request left on the bus
  endtask
  // one frame and the check of its forwarding result
  task automatic fr(input logic [12:0] vid, input logic [47:0] da, input logic [47:0] sa,
                    input logic [2:0] p, input logic [7:0] mb, input logic [9:0] e);
    u_src.send('{vid, da, sa, p, mb}, v, r);
    chk("res_valid", 64'h1, v);
    chk("res", e, r);
  endtask
  // reset values
  task automatic t_reset;
    chk("age_now", 64'h12c, age_now);
    chk("mgt_rsp", 80'h0, rsp_o);
  endtask
  // aging period span edges and readback
  task automatic t_age;
    for (int i = 0; i < 4; i++) begin
      mg(mate_pkg::MATE_OP_SET_AGE, 48'h0, 13'h0, 8'h00, ages[i]);
      chk("age_err", (i == 0 || i == 2), m.err);
      chk("age_now", after[i], age_now);
    end
  endtask
  // unknown destination floods, learned one forwards
  task automatic t_learn;
    fr(13'h0007, B, A, 3'h1, 8'h0f, {8'h0d, 2'b01});
    fr(13'h0007, A, B, 3'h2, 8'h0f, {8'h02, 2'b00});
  endtask
  // static entry and its refusal
  task automatic t_static;
    mg(mate_pkg::MATE_OP_ADD_ST, C, 13'h0005, 8'h30, 10'h000);
    chk("add_err", 64'h0, m.err);
    mg(mate_pkg::MATE_OP_ADD_ST, C, 13'h0000, 8'h30, 10'h000);
    chk("add_err", 64'h1, m.err);
    fr(13'h0005, C, A, 3'h1, 8'hff, {8'h30, 2'b00});
  endtask
  // readout walks vlan first, then mac
  task automatic t_read;
    mg(mate_pkg::MATE_OP_RD_NEXT, 48'h0, 13'h0000, 8'h00, 10'h000);
    chk("rd_first", {1'b1, 1'b1, 13'h0005, C}, {m.found, m.stat, m.vid, m.mac});
    mg(mate_pkg::MATE_OP_RD_NEXT, C, 13'h0005, 8'h00, 10'h000);
    chk("rd_second", {1'b1, 13'h0005, A, 8'h02}, {m.found, m.vid, m.mac, m.ports});
    mg(mate_pkg::MATE_OP_RD_NEXT, A, 13'h0005, 8'h00, 10'h000);
    chk("rd_third", {1'b1, 13'h0007, A}, {m.found, m.vid, m.mac});
  endtask
  // vlan span upper edge, then filter drops on source match, lifted by delete
  task automatic t_filter;
    mg(mate_pkg::MATE_OP_ADD_FL, D, 13'h1001, 8'h00, 10'h000);
    chk("fl_err", 64'h1, m.err);
    mg(mate_pkg::MATE_OP_ADD_FL, D, 13'h1000, 8'h00, 10'h000);
    chk("fl_err", 64'h0, m.err);
    mg(mate_pkg::MATE_OP_ADD_FL, D, 13'h0005, 8'h00, 10'h000);
    chk("fl_err", 64'h0, m.err);
    fr(13'h0005, A, D, 3'h3, 8'hff, {8'h00, 2'b10});
    mg(mate_pkg::MATE_OP_DEL_FL, D, 13'h0005, 8'h00, 10'h000);
    chk("fl_found", 64'h1, m.found);
    fr(13'h0005, A, D, 3'h3, 8'hff, {8'h02, 2'b00});
  endtask
  // idle learned entry ages out, static stays until deleted; then flush
  task automatic t_aging;
    mg(mate_pkg::MATE_OP_SET_AGE, 48'h0, 13'h0, 8'h00, 10'h00a);
    repeat (12 * SEC) @(posedge clk);
    fr(13'h0007, A, C, 3'h3, 8'h0f, {8'h07, 2'b01});
    fr(13'h0005, C, B, 3'h2, 8'hff, {8'h30, 2'b00});
    mg(mate_pkg::MATE_OP_DEL_ST, C, 13'h0005, 8'h00, 10'h000);
    chk("del_found", 64'h1, m.found);
    fr(13'h0005, C, B, 3'h2, 8'h3c, {8'h38, 2'b01});
    mg(mate_pkg::MATE_OP_FLUSH, 48'h0, 13'h0, 8'h00, 10'h000);
    mg(mate_pkg::MATE_OP_RD_NEXT, 48'h0, 13'h0000, 8'h00, 10'h000);
    chk("rd_empty", 64'h0, m.found);
    chk("rd_empty_fields", 80'h0, {m.stat, m.vid, m.mac, m.ports});
  endtask
  // counts and verdict, ends the run
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    t_reset();
    t_age();
    t_learn();
    t_static();
    t_read();
    t_filter();
    t_aging();
    wrap_up();
  end
  // hang guard, several times the expected run of a few hundred cycles
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
